//--- hw/tlic_top.sv
// Purpose: two-level interrupt controller with AHB-Lite register access
// Assumes: S5P2 strobe and core poll/ack/return signals synchronous to CLK
// Notes:   zero-wait slave; HREADYOUT follows CE so a frozen block stalls the bus
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`include "tlic_defines.svh"

module tlic_top (
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  // ahb-lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // request sources
  input  tlic_pkg::tlic_evt_s      EVT,
  input  wire logic                EXT0_N,
  input  wire logic                EXT1_N,
  // machine-cycle timing and core handshake
  input  wire logic                S5P2,
  input  wire logic                POLL_OK,
  input  wire logic                VEC_ACK,
  input  wire logic                RETURN_FROM_ISR,
  output logic                     VEC_REQ,
  output logic      [15:0]         VEC_ADDR,
  output logic                     VEC_LEVEL_HI,
  output logic      [1:0]          IN_PROGRESS
);
  import tlic_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  irq_enable_reg;
  logic [7:0]  irq_priority_reg;
  logic [7:0]  flags;
  logic [7:0]  next_flags;
  logic [1:0]  ext_edge_mode;
  logic [1:0]  pin_prev_hi;
  logic        ip_lo;
  logic        ip_hi;
  logic        next_ip_lo;
  logic        next_ip_hi;
  tlic_win_s   win;
  tlic_win_s   poll;
  logic [5:0]  src_req;
  logic [5:0]  gated_req;
  logic [5:0]  level_hi;
  logic        global_irq_gate;
  logic        ack;
  logic        return_from_isr;

  // bus data-phase state
  logic        dph_wr;
  logic [7:0]  dph_ofs;
  logic        aph_valid;
  logic [7:0]  aph_ofs;
  logic        wr_enable;
  logic        wr_priority;
  logic        wr_flags;
  logic        wr_mode;
  logic [31:0] rd_mux;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  // only whole-word transfers are expected; HSIZE is not checked
  assign HREADYOUT = CE;
  assign HRESP     = 1'b0;
  assign aph_valid = HSEL & HTRANS[1] & HREADY & CE;
  assign aph_ofs   = HADDR[7:0];

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dph_wr  <= 1'b0;
      dph_ofs <= 8'h00;
    end else if (CE && HREADY) begin
      dph_wr  <= aph_valid & HWRITE;
      dph_ofs <= aph_ofs;
    end
  end

  assign wr_enable   = CE & dph_wr & (dph_ofs == `TLIC_OFS_ENABLE);
  assign wr_priority = CE & dph_wr & (dph_ofs == `TLIC_OFS_PRIORITY);
  assign wr_flags    = CE & dph_wr & (dph_ofs == `TLIC_OFS_FLAGS);
  assign wr_mode     = CE & dph_wr & (dph_ofs == `TLIC_OFS_MODE);

  always_comb begin
    unique case (aph_ofs)
      `TLIC_OFS_ENABLE:   rd_mux = {24'h000000, irq_enable_reg};
      `TLIC_OFS_PRIORITY: rd_mux = {24'h000000, irq_priority_reg};
      `TLIC_OFS_FLAGS:    rd_mux = {24'h000000, flags};
      `TLIC_OFS_MODE:     rd_mux = {30'h00000000, ext_edge_mode};
      `TLIC_OFS_STATUS:   rd_mux = {25'h0000000, win.valid, win.hi, win.src, ip_hi, ip_lo};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // read data captured at the address phase, so it stands through the data phase
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h00000000;
    end else if (aph_valid && !HWRITE) begin
      HRDATA <= rd_mux;
    end
  end

  // ****************************************************************
  // enable, priority and mode registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_enable_reg <= `TLIC_ENABLE_RST;
    end else if (wr_enable) begin
      irq_enable_reg <= HWDATA[7:0] & `TLIC_EN_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_priority_reg <= `TLIC_PRIORITY_RST;
    end else if (wr_priority) begin
      irq_priority_reg <= HWDATA[7:0] & `TLIC_PRI_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_edge_mode <= `TLIC_MODE_RST;
    end else if (wr_mode) begin
      ext_edge_mode <= HWDATA[1:0];
    end
  end

  // ****************************************************************
  // request flags
  // ****************************************************************
  assign ack  = CE & VEC_ACK & win.valid;
  assign return_from_isr = CE & RETURN_FROM_ISR;

  // previous pin samples for edge detection, taken once per machine cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_prev_hi <= 2'b11;
    end else if (CE && S5P2) begin
      pin_prev_hi <= {EXT1_N, EXT0_N};
    end
  end

  // order: software write, then vectoring clears, then hardware sets, so a set
  // landing in the same cycle as any clear is kept
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = HWDATA[7:0];
    end
    if (ack) begin
      unique case (win.src)
        TLIC_SRC_TIMER0: next_flags[`TLIC_FLG_TF0] = 1'b0;
        TLIC_SRC_TIMER1: next_flags[`TLIC_FLG_TF1] = 1'b0;
        TLIC_SRC_EXT0: begin
          if (ext_edge_mode[`TLIC_MODE_EDGE0]) begin
            next_flags[`TLIC_FLG_EXT0] = 1'b0;
          end
        end
        TLIC_SRC_EXT1: begin
          if (ext_edge_mode[`TLIC_MODE_EDGE1]) begin
            next_flags[`TLIC_FLG_EXT1] = 1'b0;
          end
        end
        TLIC_SRC_SERIAL: ;
        TLIC_SRC_TIMER2: ;
      endcase
    end
    next_flags[`TLIC_FLG_TF0]  = next_flags[`TLIC_FLG_TF0]  | EVT.t0_ovf;
    next_flags[`TLIC_FLG_TF1]  = next_flags[`TLIC_FLG_TF1]  | EVT.t1_ovf;
    next_flags[`TLIC_FLG_TF2]  = next_flags[`TLIC_FLG_TF2]  | EVT.t2_ovf;
    next_flags[`TLIC_FLG_TIMER2_EXTERNAL_FLAG] = next_flags[`TLIC_FLG_TIMER2_EXTERNAL_FLAG] | EVT.t2_ext;
    next_flags[`TLIC_FLG_RX]   = next_flags[`TLIC_FLG_RX]   | EVT.rx_done;
    next_flags[`TLIC_FLG_TX]   = next_flags[`TLIC_FLG_TX]   | EVT.tx_done;
    if (S5P2) begin
      // level mode: the pin owns the flag; edge mode: high then low sets it
      if (ext_edge_mode[`TLIC_MODE_EDGE0]) begin
        next_flags[`TLIC_FLG_EXT0] = next_flags[`TLIC_FLG_EXT0]
                                     | (pin_prev_hi[0] & ~EXT0_N);
      end else begin
        next_flags[`TLIC_FLG_EXT0] = ~EXT0_N;
      end
      if (ext_edge_mode[`TLIC_MODE_EDGE1]) begin
        next_flags[`TLIC_FLG_EXT1] = next_flags[`TLIC_FLG_EXT1]
                                     | (pin_prev_hi[1] & ~EXT1_N);
      end else begin
        next_flags[`TLIC_FLG_EXT1] = ~EXT1_N;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags <= `TLIC_FLAGS_RST;
    end else if (CE) begin
      flags <= next_flags;
    end
  end

  // ****************************************************************
  // source requests and gating
  // ****************************************************************
  assign src_req[TLIC_SRC_EXT0]   = flags[`TLIC_FLG_EXT0];
  assign src_req[TLIC_SRC_TIMER0] = flags[`TLIC_FLG_TF0];
  assign src_req[TLIC_SRC_EXT1]   = flags[`TLIC_FLG_EXT1];
  assign src_req[TLIC_SRC_TIMER1] = flags[`TLIC_FLG_TF1];
  assign src_req[TLIC_SRC_SERIAL] = flags[`TLIC_FLG_RX] | flags[`TLIC_FLG_TX];
  assign src_req[TLIC_SRC_TIMER2] = flags[`TLIC_FLG_TF2] | flags[`TLIC_FLG_TIMER2_EXTERNAL_FLAG];

  assign global_irq_gate = irq_enable_reg[`TLIC_EN_GATE_BIT];
  assign gated_req = src_req & irq_enable_reg[5:0] & {6{global_irq_gate}};
  assign level_hi  = irq_priority_reg[5:0];

  tlic_arbiter u_arbiter (
    .req     (gated_req),
    .hi      (level_hi),
    .busy_lo (ip_lo),
    .busy_hi (ip_hi),
    .win     (poll)
  );

  // ****************************************************************
  // polling: snapshot at S5P2, offered during the following cycle
  // ****************************************************************
  // each S5P2 replaces the snapshot, so a request that was blocked and has
  // since dropped is simply gone
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      win <= '0;
    end else if (CE) begin
      if (S5P2) begin
        win <= poll;
      end else if (ack) begin
        win.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      VEC_ADDR     <= 16'h0000;
      VEC_LEVEL_HI <= 1'b0;
    end else if (CE && S5P2) begin
      VEC_ADDR     <= `TLIC_VEC_BASE + {10'h000, poll.src, 3'h0};
      VEC_LEVEL_HI <= poll.hi;
    end
  end

  // the core runs the call only in an instruction's final cycle, outside a
  // return or an access to these registers; POLL_OK carries that judgement
  assign VEC_REQ = win.valid & POLL_OK;

  // ****************************************************************
  // in-progress markers
  // ****************************************************************
  always_comb begin
    next_ip_lo = ip_lo;
    next_ip_hi = ip_hi;
    if (return_from_isr) begin
      if (ip_hi) begin
        next_ip_hi = 1'b0;
      end else begin
        next_ip_lo = 1'b0;
      end
    end
    if (ack) begin
      if (win.hi) begin
        next_ip_hi = 1'b1;
      end else begin
        next_ip_lo = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ip_lo <= 1'b0;
      ip_hi <= 1'b0;
    end else if (CE) begin
      ip_lo <= next_ip_lo;
      ip_hi <= next_ip_hi;
    end
  end

  assign IN_PROGRESS = {ip_hi, ip_lo};

endmodule

//--- common/tlic_defines.svh
// Purpose: constants of the two-level interrupt controller (offsets, fields, resets, vectors)
// Assumes: included by bare name after the package is compiled
// Notes:   definitions only
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TLIC_OFS_ENABLE   8'h00
`define TLIC_OFS_PRIORITY 8'h04
`define TLIC_OFS_FLAGS    8'h08
`define TLIC_OFS_MODE     8'h0c
`define TLIC_OFS_STATUS   8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define TLIC_EN_GATE_BIT  7
`define TLIC_EN_WMASK     8'hbf
`define TLIC_PRI_WMASK    8'h3f
`define TLIC_NUM_SRC      6
`define TLIC_FLG_EXT0     0
`define TLIC_FLG_TF0      1
`define TLIC_FLG_EXT1     2
`define TLIC_FLG_TF1      3
`define TLIC_FLG_RX       4
`define TLIC_FLG_TX       5
`define TLIC_FLG_TF2      6
`define TLIC_FLG_TIMER2_EXTERNAL_FLAG     7
`define TLIC_MODE_EDGE0   0
`define TLIC_MODE_EDGE1   1

// ****************************************************************
// reset values and vectors
// ****************************************************************
`define TLIC_ENABLE_RST   8'h00
`define TLIC_PRIORITY_RST 8'h00
`define TLIC_FLAGS_RST    8'h00
`define TLIC_MODE_RST     2'h0
`define TLIC_VEC_BASE     16'h0003
`define TLIC_VEC_STRIDE   16'h0008

`endif

//--- common/tlic_pkg.sv
// Purpose: types shared by the interrupt controller modules
// Assumes: nothing
// Notes:   source codes follow the fixed polling order, ext0 first
package tlic_pkg;

  typedef enum logic [2:0] {
    TLIC_SRC_EXT0   = 3'b000,
    TLIC_SRC_TIMER0 = 3'b001,
    TLIC_SRC_EXT1   = 3'b010,
    TLIC_SRC_TIMER1 = 3'b011,
    TLIC_SRC_SERIAL = 3'b100,
    TLIC_SRC_TIMER2 = 3'b101
  } tlic_src_e;

  // poll result: one pending vector
  typedef struct packed {
    logic      valid;
    logic      hi;
    tlic_src_e src;
  } tlic_win_s;

  // hardware events from timers and serial port; the external pins come in separately
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_ovf;
    logic t2_ext;
    logic rx_done;
    logic tx_done;
  } tlic_evt_s;

endpackage

//--- hw/tlic_arbiter.sv
// Purpose: picks the source to vector to from gated requests and levels
// Assumes: requests already gated by enables
// Notes:   purely combinational
module tlic_arbiter (
  input  wire logic [5:0]         req,
  input  wire logic [5:0]         hi,
  input  wire logic               busy_lo,
  input  wire logic               busy_hi,
  output tlic_pkg::tlic_win_s     win
);
  import tlic_pkg::*;

  logic [5:0] hi_req;
  logic [5:0] lo_req;
  logic [5:0] pick;
  logic       use_hi;

  always_comb begin
    hi_req = req & hi & {6{~busy_hi}};
    lo_req = req & ~hi & {6{~busy_hi & ~busy_lo}};
    use_hi = |hi_req;
    pick   = use_hi ? hi_req : lo_req;
    win    = '0;
    // lowest index wins: scan downward so the last hit is the first in order
    for (int i = 5; i >= 0; i--) begin
      if (pick[i]) begin
        win.valid = 1'b1;
        win.hi    = use_hi;
        win.src   = tlic_src_e'(3'(i));
      end
    end
  end

endmodule

//--- tb/tlic_asserts.sv
// Purpose: concurrent checks on the vector handshake of tlic_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every tlic_top instance
module tlic_asserts (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        S5P2,
  input wire logic        VEC_ACK,
  input wire logic        RETURN_FROM_ISR,
  input wire logic        VEC_REQ,
  input wire logic [15:0] VEC_ADDR,
  input wire logic        VEC_LEVEL_HI,
  input wire logic [1:0]  IN_PROGRESS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_vec_in_table: assert property (
    VEC_REQ |-> VEC_ADDR[2:0] == 3'h3 && VEC_ADDR <= 16'h002b)
    else $error("vector outside the table");
  // the vector is a snapshot: it may only move at a poll or an acknowledge
  a_snapshot_holds: assert property (
    !S5P2 && !VEC_ACK |=> $stable(VEC_ADDR) && $stable(VEC_LEVEL_HI))
    else $error("vector changed between polls");
  a_hi_blocks_all: assert property (
    S5P2 && IN_PROGRESS[1] && !VEC_ACK && !RETURN_FROM_ISR |=> !VEC_REQ)
    else $error("vector raised inside a high routine");
  a_lo_waits: assert property (
    S5P2 && IN_PROGRESS == 2'b01 && !VEC_ACK && !RETURN_FROM_ISR |=> !VEC_REQ || VEC_LEVEL_HI)
    else $error("low request preempted a low routine");
  a_ack_marks_hi: assert property (
    VEC_ACK && VEC_REQ && VEC_LEVEL_HI |=> IN_PROGRESS[1])
    else $error("high marker not set by acknowledge");
  a_ack_marks_lo: assert property (
    VEC_ACK && VEC_REQ && !VEC_LEVEL_HI |=> IN_PROGRESS[0])
    else $error("low marker not set by acknowledge");
  a_ret_hi_first: assert property (
    RETURN_FROM_ISR && !VEC_ACK && IN_PROGRESS == 2'b11 |=> IN_PROGRESS == 2'b01)
    else $error("return did not end the high routine first");
  a_ret_lo_only: assert property (
    RETURN_FROM_ISR && !VEC_ACK && IN_PROGRESS == 2'b01 |=> IN_PROGRESS == 2'b00)
    else $error("return did not end the low routine");
  a_marks_steady: assert property (
    !VEC_ACK && !RETURN_FROM_ISR |=> $stable(IN_PROGRESS))
    else $error("in-progress markers moved by themselves");
endmodule

bind tlic_top tlic_asserts u_chk (
  .CLK, .RST_B, .S5P2, .VEC_ACK, .RETURN_FROM_ISR, .VEC_REQ, .VEC_ADDR, .VEC_LEVEL_HI,
  .IN_PROGRESS
);

//--- tb/tlic_core_model.sv
// Purpose: behavioural processor core facing the controller's vector handshake
// Assumes: four clocks stand for one machine cycle
// Notes:   acknowledges every request it sees and records the vector taken
module tlic_core_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        vec_req,
  input  wire logic [15:0] vec_addr,
  output logic             s5p2,
  output logic             poll_ok,
  output logic             vec_ack,
  output logic [15:0]      last_vec,
  output logic [7:0]       n_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase   <= 2'h0;
      s5p2    <= 1'b0;
      poll_ok <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      s5p2  <= (phase == 2'h2);
      // only every other machine cycle ends an instruction, so polls get lost
      if (s5p2) begin
        poll_ok <= !poll_ok;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_ack  <= 1'b0;
      last_vec <= 16'h0000;
      n_ack    <= 8'h00;
    end else begin
      vec_ack <= vec_req && !vec_ack;
      if (vec_ack) begin
        last_vec <= vec_addr;
        n_ack    <= n_ack + 8'h01;
      end
    end
  end
endmodule

//--- tb/tb.sv
// Purpose: self-checking bench for tlic_top over its register bus and core handshake
// Assumes: CE held high, so the slave answers with zero wait
// Notes:   external flags kept in edge mode unless a test says otherwise
`include "tlic_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ofs_en  = `TLIC_OFS_ENABLE;
  localparam logic [7:0] ofs_pri = `TLIC_OFS_PRIORITY;
  localparam logic [7:0] ofs_fl  = `TLIC_OFS_FLAGS;
  localparam logic [7:0] ofs_md  = `TLIC_OFS_MODE;
  localparam logic [7:0] ofs_st  = `TLIC_OFS_STATUS;
  logic                clk, rst_b, hsel, hwrite, hready, ext0_n, ret;
  logic                s5p2, poll_ok, vec_ack, vec_req;
  logic [1:0]          htrans, ip_out;
  logic                hresp;
  logic [7:0]          n_ack, fl, msk;
  logic [15:0]         vec_addr, last_vec;
  logic [31:0]         haddr, hwdata, hrdata;
  tlic_pkg::tlic_evt_s evt;
  int                  fail_count, n_compared;

  tlic_top DUT (
    .CLK(clk), .RST_B(rst_b), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .EVT(evt), .EXT0_N(ext0_n), .EXT1_N(1'b1), .S5P2(s5p2),
    .POLL_OK(poll_ok), .VEC_ACK(vec_ack), .RETURN_FROM_ISR(ret), .VEC_REQ(vec_req),
    .VEC_ADDR(vec_addr), .VEC_LEVEL_HI(), .IN_PROGRESS(ip_out));

  tlic_core_model u_core (
    .clk(clk), .rst_b(rst_b), .vec_req(vec_req), .vec_addr(vec_addr), .s5p2(s5p2),
    .poll_ok(poll_ok), .vec_ack(vec_ack), .last_vec(last_vec), .n_ack(n_ack));

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(a, 1'b1, {24'h0, d}, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(x, {24'h0, e});
  endtask

  task automatic chk_ip(input logic [1:0] ip);
    logic [31:0] x;
    bus(ofs_st, 1'b0, 32'h0, x);
    chk({30'h0, x[1:0]}, {30'h0, ip});
    // the marker pins must agree with the status word
    chk({30'h0, ip_out}, {30'h0, ip});
    chk({31'h0, hresp}, 32'h0);
  endtask

  // six machine cycles cover a lost poll plus the two-cycle call
  task automatic expect_ack(input logic e);
    logic [7:0] n0;
    n0 = n_ack;
    for (int i = 0; i < 24 && n_ack === n0; i++) begin
      @(posedge clk);
    end
    chk({31'h0, n_ack !== n0}, {31'h0, e});
  endtask

  task automatic serve(input logic [15:0] v, input logic [7:0] f, input logic [1:0] ip);
    expect_ack(1'b1);
    chk({16'h0, last_vec}, {16'h0, v});
    rdc(ofs_fl, f);
    chk_ip(ip);
  endtask

  task automatic iret();
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(posedge clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext0_n = 1'b1;
    ret = 1'b0;
    evt = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(ofs_en, 8'h00);
    rdc(ofs_pri, 8'h00);
    rdc(8'h14, 8'h00);
    wr(ofs_en, 8'hff);
    rdc(ofs_en, 8'hbf);
    wr(ofs_pri, 8'hff);
    rdc(ofs_pri, 8'h3f);
    wr(ofs_pri, 8'h00);
    wr(ofs_en, 8'h00);
    wr(ofs_md, 8'h03);
    evt.t0_ovf <= 1'b1;
    @(posedge clk);
    evt.t0_ovf <= 1'b0;
    rdc(ofs_fl, 8'h02);
    wr(ofs_en, 8'h02);
    expect_ack(1'b0);
    wr(ofs_en, 8'h80);
    expect_ack(1'b0);
    wr(ofs_en, 8'h82);
    serve(16'h000b, 8'h00, 2'b01);
    iret();
    chk_ip(2'b00);
    wr(ofs_en, 8'h02);
    wr(ofs_fl, 8'h02);
    repeat (8) @(posedge clk);
    wr(ofs_fl, 8'h00);
    wr(ofs_en, 8'h82);
    expect_ack(1'b0);
    // all sources at once: polling order, vectors and which flags survive
    wr(ofs_en, 8'hbf);
    fl = 8'hff;
    wr(ofs_fl, fl);
    for (int s = 0; s < 6; s++) begin
      msk = (s < 4) ? 8'h01 << s : ((s == 4) ? 8'h30 : 8'hc0);
      serve(16'h0003 + 16'(8 * s), (s < 4) ? fl & ~msk : fl, 2'b01);
      fl = fl & ~msk;
      wr(ofs_fl, fl);
      iret();
    end
    wr(ofs_fl, 8'h20);
    serve(16'h0023, 8'h20, 2'b01);
    wr(ofs_fl, 8'h80);
    iret();
    serve(16'h002b, 8'h80, 2'b01);
    wr(ofs_fl, 8'h00);
    iret();
    wr(ofs_pri, 8'h20);
    wr(ofs_fl, 8'h82);
    serve(16'h002b, 8'h82, 2'b10);
    wr(ofs_pri, 8'h24);
    wr(ofs_fl, 8'h86);
    expect_ack(1'b0);
    wr(ofs_fl, 8'h06);
    iret();
    serve(16'h0013, 8'h02, 2'b10);
    iret();
    serve(16'h000b, 8'h00, 2'b01);
    wr(ofs_fl, 8'h0c);
    serve(16'h0013, 8'h08, 2'b11);
    iret();
    expect_ack(1'b0);
    iret();
    serve(16'h001b, 8'h00, 2'b01);
    iret();
    // level mode: the pin, not the acknowledge, owns the flag
    wr(ofs_pri, 8'h00);
    wr(ofs_md, 8'h00);
    ext0_n <= 1'b0;
    serve(16'h0003, 8'h01, 2'b01);
    ext0_n <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(ofs_fl, 8'h00);
    iret();
    end_sim();
  end
endmodule
